// ===== logic/charger_regs_pkg.sv
package charger_regs_pkg;

  // Register offsets, one byte each
  localparam logic [7:0] CHARGER_STATE_FLAGS_OFF       = 8'h00;
  localparam logic [7:0] CHARGE_PROGRESS_FLAGS_OFF     = 8'h01;
  localparam logic [7:0] INPUT_THERMAL_FLAGS_OFF       = 8'h02;
  localparam logic [7:0] EVENT_FLAGS_A_OFF             = 8'h04;
  localparam logic [7:0] EVENT_FLAGS_B_OFF             = 8'h05;
  localparam logic [7:0] EVENT_FLAGS_C_OFF             = 8'h06;
  localparam logic [7:0] EVENT_MASK_A_OFF              = 8'h08;
  localparam logic [7:0] EVENT_MASK_B_OFF              = 8'h09;
  localparam logic [7:0] EVENT_MASK_C_OFF              = 8'h0a;
  localparam logic [7:0] BATTERY_THRESHOLD_CTRL_OFF    = 8'h0c;
  localparam logic [7:0] REGULATOR_OUTPUT_CTRL_OFF     = 8'h0d;
  localparam logic [7:0] CHARGE_BEHAVIOUR_CTRL_OFF     = 8'h0e;
  localparam logic [7:0] RESET_POWERPATH_CTRL_OFF      = 8'h0f;
  localparam logic [7:0] FLOAT_VOLTAGE_SETTING_OFF     = 8'h11;
  localparam logic [7:0] CHARGE_CURRENT_SETTING_OFF    = 8'h12;
  localparam logic [7:0] TERMINATION_PRECHARGE_OFF     = 8'h13;
  localparam logic [7:0] PRIMARY_INPUT_CURRENT_OFF     = 8'h14;
  localparam logic [7:0] PRIMARY_INPUT_VOLTAGE_OFF     = 8'h15;
  localparam logic [7:0] SECONDARY_INPUT_CURRENT_OFF   = 8'h16;
  localparam logic [7:0] SECONDARY_INPUT_VOLTAGE_OFF   = 8'h17;
  localparam logic [7:0] THERMISTOR_ZONE_CTRL_OFF      = 8'h18;
  localparam logic [7:0] CHARGE_TIMER_CTRL_OFF         = 8'h19;
  localparam logic [7:0] SAFETY_LIMIT_SETTING_OFF      = 8'h1a;
  localparam logic [7:0] TOP_OFF_CTRL_OFF              = 8'h1b;
  localparam logic [7:0] BOOST_CTRL_OFF                = 8'h1c;
  localparam logic [7:0] ADAPTER_DETECT_CTRL_OFF       = 8'h1f;
  localparam logic [7:0] COMPARATOR_MONITOR_A_OFF      = 8'h20;
  localparam logic [7:0] COMPARATOR_MONITOR_B_OFF      = 8'h21;
  localparam logic [7:0] DEVICE_IDENTITY_OFF           = 8'h2d;
  localparam logic [7:0] FEATURE_OPTIONS_OFF           = 8'h30;

  // Bit positions inside the charger state register
  localparam int STATE_RESERVED_BIT  = 7;
  localparam int STATE_SECONDARY_BIT = 6;
  localparam int STATE_PRIMARY_BIT   = 5;
  localparam int STATE_BATT_LOW_BIT  = 4;
  localparam int STATE_CHARGING_BIT  = 3;
  localparam int STATE_PRECHARGE_BIT = 2;
  localparam int STATE_SLEEP_BIT     = 1;
  localparam int STATE_ABSENT_BIT    = 0;

  // Reset values, battery attached and no input supply
  localparam logic [7:0] CHARGER_STATE_FLAGS_RST = 8'h82;
  localparam logic [7:0] STATUS_ZERO_RST         = 8'h00;
  localparam logic [7:0] COMPARATOR_MONITOR_A_RST = 8'h86;
  localparam logic [7:0] COMPARATOR_MONITOR_B_RST = 8'ha0;

  // Identity value is arbitrary, not that of any real part
  localparam logic [7:0] DEVICE_IDENTITY_VAL = 8'h5a;

  // Request from the serial protocol engine, same clock
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Levels and flags coming from the analog charger core
  typedef struct packed {
    logic       secondary_rise_ok;
    logic       primary_input_ok;
    logic       battery_above_weak;
    logic       charging;
    logic       top_off;
    logic       precharge;
    logic       sleep;
    logic       battery_absent;
    logic       high_impedance_state;
    logic       validation_pass;
    logic [7:0] progress;
    logic [7:0] input_thermal;
    logic [7:0] monitor_a;
    logic [7:0] monitor_b;
    logic [7:0] events_a;
    logic [7:0] events_b;
    logic [7:0] events_c;
  } core_in_type;

  localparam core_in_type CORE_IN_RST = '{
    sleep: 1'b1, monitor_a: COMPARATOR_MONITOR_A_RST,
    monitor_b: COMPARATOR_MONITOR_B_RST, default: '0};

  // Writable settings handed to the charger core
  typedef struct packed {
    logic [7:0] event_mask_a;
    logic [7:0] event_mask_b;
    logic [7:0] event_mask_c;
    logic [7:0] battery_threshold_ctrl;
    logic [7:0] regulator_output_ctrl;
    logic [7:0] charge_behaviour_ctrl;
    logic [7:0] reset_powerpath_ctrl;
    logic [7:0] float_voltage_setting;
    logic [7:0] charge_current_setting;
    logic [7:0] termination_precharge_current;
    logic [7:0] primary_input_current_limit;
    logic [7:0] primary_input_voltage_limits;
    logic [7:0] secondary_input_current_limit;
    logic [7:0] secondary_input_voltage_limits;
    logic [7:0] thermistor_zone_ctrl;
    logic [7:0] charge_timer_ctrl;
    logic [7:0] safety_limit_setting;
    logic [7:0] top_off_ctrl;
    logic [7:0] boost_ctrl;
    logic [7:0] adapter_detect_ctrl;
    logic [7:0] feature_options;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = '{
    event_mask_a:                   8'h00,
    event_mask_b:                   8'h00,
    event_mask_c:                   8'h00,
    battery_threshold_ctrl:         8'h3f,
    regulator_output_ctrl:          8'h57,
    charge_behaviour_ctrl:          8'h1c,
    reset_powerpath_ctrl:           8'h40,
    float_voltage_setting:          8'h69,
    charge_current_setting:         8'h10,
    termination_precharge_current:  8'h98,
    primary_input_current_limit:    8'h10,
    primary_input_voltage_limits:   8'h24,
    secondary_input_current_limit:  8'h1b,
    secondary_input_voltage_limits: 8'h14,
    thermistor_zone_ctrl:           8'h0f,
    charge_timer_ctrl:              8'h1b,
    safety_limit_setting:           8'hff,
    top_off_ctrl:                   8'h03,
    boost_ctrl:                     8'h12,
    adapter_detect_ctrl:            8'h00,
    feature_options:                8'h20};

endpackage

// ===== logic/level_sync.sv
module level_sync
  import charger_regs_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;  // First stage, read only by the second

  // Two flops; reset value keeps the default visible before real data arrives
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // level_sync

// ===== logic/charger_register_bank.sv
// Summary of operation
// - Reset loads battery-only default values
// - State bit 7 always reads one
// - Secondary valid only without valid primary
// - Primary valid while validated and in range
// - Battery-above-weak flag held through high impedance
// - Validate source on leaving high impedance
// - Charging bit excludes top-off, drives status pin
// - Pre-charge bit follows pre-charge mode
// - Sleep bit follows sleep mode
// - Absent bit set when no battery found
module charger_register_bank
  import charger_regs_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Byte access from the serial protocol engine
  input  wire reg_req_type  req,
  output logic        [7:0] rd_data_reg,
  output logic              rd_valid_reg,
  // Levels from the analog charger core
  input  wire core_in_type  core_in,
  // Settings and requests to the charger core
  output ctrl_type          ctrl_reg,
  output logic              validate_start_reg,
  // Open-drain charge status pin
  output logic              charge_status_out_reg,
  output logic              charge_status_oe_reg
);

  core_in_type core_s;               // Core levels after synchroniser
  logic [7:0]  state_reg;            // Charger state flags
  logic [7:0]  state_next;           // Next charger state flags
  logic [7:0]  progress_reg;         // Charge progress flags
  logic [7:0]  thermal_reg;          // Input and thermal flags
  logic [7:0]  monitor_a_reg;        // Comparator monitor A
  logic [7:0]  monitor_b_reg;        // Comparator monitor B
  logic [7:0]  flags_a_reg;          // Sticky event flags A
  logic [7:0]  flags_b_reg;          // Sticky event flags B
  logic [7:0]  flags_c_reg;          // Sticky event flags C
  logic [23:0] events_prev_reg;      // Last event levels for edges
  logic [23:0] event_edge;           // Rising edges of events
  logic        impedance_prev_reg;   // Last high-impedance level
  logic        validation_busy_reg;  // Source validation in flight
  logic        weak_hold_reg;        // Holds battery flag across high impedance
  logic        charge_mode;          // Charging but not topping off
  logic        impedance_exit;       // High impedance just left
  logic        impedance_enter;      // High impedance just entered

  // Bring all core levels into the clock domain
  level_sync #(
    .WIDTH     ($bits(core_in_type)),
    .RESET_VAL (CORE_IN_RST)
  ) u_core_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (core_in),
    .sync_out (core_s)
  );

  assign charge_mode     = core_s.charging && !core_s.top_off;
  assign impedance_exit  = impedance_prev_reg && !core_s.high_impedance_state;
  assign impedance_enter = !impedance_prev_reg && core_s.high_impedance_state;

  // Track high-impedance entry and exit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      impedance_prev_reg <= 1'b0;
    end else begin
      impedance_prev_reg <= core_s.high_impedance_state;
    end
  end

  // Start validation on each exit; flags stay low until it passes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      validation_busy_reg <= 1'b0;
      validate_start_reg  <= 1'b0;
    end else begin
      validate_start_reg <= impedance_exit;
      if (impedance_exit) begin
        validation_busy_reg <= 1'b1;
      end else if (core_s.validation_pass) begin
        validation_busy_reg <= 1'b0;
      end
    end
  end

  // Weak-battery hold: set on entry with flag high, released on recharge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      weak_hold_reg <= 1'b0;
    end else if (impedance_enter && state_reg[STATE_BATT_LOW_BIT]) begin
      weak_hold_reg <= 1'b1;
    end else if (!validation_busy_reg && !impedance_prev_reg
                 && !core_s.high_impedance_state
                 && core_s.validation_pass && core_s.charging) begin
      // Only after the exit and a fresh validation, never inside high impedance
      weak_hold_reg <= 1'b0;
    end
  end

  // Compose the charger state flags
  always_comb begin
    state_next                      = '0;
    state_next[STATE_RESERVED_BIT]  = 1'b1;
    state_next[STATE_PRIMARY_BIT]   = core_s.primary_input_ok
                                      && !validation_busy_reg;
    state_next[STATE_SECONDARY_BIT] = core_s.secondary_rise_ok
                                      && !validation_busy_reg
                                      && !state_next[STATE_PRIMARY_BIT];
    state_next[STATE_BATT_LOW_BIT]  = weak_hold_reg
                                      || (impedance_enter && state_reg[STATE_BATT_LOW_BIT])
                                      || (core_s.battery_above_weak
                                          && core_s.charging);
    state_next[STATE_CHARGING_BIT]  = charge_mode;
    state_next[STATE_PRECHARGE_BIT] = core_s.precharge;
    state_next[STATE_SLEEP_BIT]     = core_s.sleep;
    state_next[STATE_ABSENT_BIT]    = core_s.battery_absent;
  end

  // Read-only status images, refreshed every cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= CHARGER_STATE_FLAGS_RST;
      progress_reg  <= STATUS_ZERO_RST;
      thermal_reg   <= STATUS_ZERO_RST;
      monitor_a_reg <= COMPARATOR_MONITOR_A_RST;
      monitor_b_reg <= COMPARATOR_MONITOR_B_RST;
    end else begin
      state_reg     <= state_next;
      progress_reg  <= core_s.progress;
      thermal_reg   <= core_s.input_thermal;
      monitor_a_reg <= core_s.monitor_a;
      monitor_b_reg <= core_s.monitor_b;
    end
  end

  // Status pin pulled low while charging outside top-off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      charge_status_oe_reg  <= 1'b0;
      charge_status_out_reg <= 1'b0;
    end else begin
      charge_status_oe_reg  <= charge_mode;
      charge_status_out_reg <= 1'b0;
    end
  end

  assign event_edge = {core_s.events_a, core_s.events_b, core_s.events_c}
                      & ~events_prev_reg;

  // Sticky events, cleared by reading; a new edge wins over the clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      events_prev_reg <= '0;
      flags_a_reg     <= STATUS_ZERO_RST;
      flags_b_reg     <= STATUS_ZERO_RST;
      flags_c_reg     <= STATUS_ZERO_RST;
    end else begin
      events_prev_reg <= {core_s.events_a, core_s.events_b, core_s.events_c};
      flags_a_reg <= ((req.rd && req.addr == EVENT_FLAGS_A_OFF) ? 8'h00 : flags_a_reg)
                     | event_edge[23:16];
      flags_b_reg <= ((req.rd && req.addr == EVENT_FLAGS_B_OFF) ? 8'h00 : flags_b_reg)
                     | event_edge[15:8];
      flags_c_reg <= ((req.rd && req.addr == EVENT_FLAGS_C_OFF) ? 8'h00 : flags_c_reg)
                     | event_edge[7:0];
    end
  end

  // Writable registers; unknown or read-only offsets drop the write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (req.wr) begin
      unique case (req.addr)
        EVENT_MASK_A_OFF:            ctrl_reg.event_mask_a <= req.wdata;
        EVENT_MASK_B_OFF:            ctrl_reg.event_mask_b <= req.wdata;
        EVENT_MASK_C_OFF:            ctrl_reg.event_mask_c <= req.wdata;
        BATTERY_THRESHOLD_CTRL_OFF:  ctrl_reg.battery_threshold_ctrl <= req.wdata;
        REGULATOR_OUTPUT_CTRL_OFF:   ctrl_reg.regulator_output_ctrl <= req.wdata;
        CHARGE_BEHAVIOUR_CTRL_OFF:   ctrl_reg.charge_behaviour_ctrl <= req.wdata;
        RESET_POWERPATH_CTRL_OFF:    ctrl_reg.reset_powerpath_ctrl <= req.wdata;
        FLOAT_VOLTAGE_SETTING_OFF:   ctrl_reg.float_voltage_setting <= req.wdata;
        CHARGE_CURRENT_SETTING_OFF:  ctrl_reg.charge_current_setting <= req.wdata;
        TERMINATION_PRECHARGE_OFF:   ctrl_reg.termination_precharge_current <= req.wdata;
        PRIMARY_INPUT_CURRENT_OFF:   ctrl_reg.primary_input_current_limit <= req.wdata;
        PRIMARY_INPUT_VOLTAGE_OFF:   ctrl_reg.primary_input_voltage_limits <= req.wdata;
        SECONDARY_INPUT_CURRENT_OFF: ctrl_reg.secondary_input_current_limit <= req.wdata;
        SECONDARY_INPUT_VOLTAGE_OFF: ctrl_reg.secondary_input_voltage_limits <= req.wdata;
        THERMISTOR_ZONE_CTRL_OFF:    ctrl_reg.thermistor_zone_ctrl <= req.wdata;
        CHARGE_TIMER_CTRL_OFF:       ctrl_reg.charge_timer_ctrl <= req.wdata;
        SAFETY_LIMIT_SETTING_OFF:    ctrl_reg.safety_limit_setting <= req.wdata;
        TOP_OFF_CTRL_OFF:            ctrl_reg.top_off_ctrl <= req.wdata;
        BOOST_CTRL_OFF:              ctrl_reg.boost_ctrl <= req.wdata;
        ADAPTER_DETECT_CTRL_OFF:     ctrl_reg.adapter_detect_ctrl <= req.wdata;
        FEATURE_OPTIONS_OFF:         ctrl_reg.feature_options <= req.wdata;
        default: begin
          // Read-only or unmapped: no effect
        end
      endcase
    end
  end

  // Read path, answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= req.rd;
      if (req.rd) begin
        unique case (req.addr)
          CHARGER_STATE_FLAGS_OFF:     rd_data_reg <= state_reg;
          CHARGE_PROGRESS_FLAGS_OFF:   rd_data_reg <= progress_reg;
          INPUT_THERMAL_FLAGS_OFF:     rd_data_reg <= thermal_reg;
          EVENT_FLAGS_A_OFF:           rd_data_reg <= flags_a_reg;
          EVENT_FLAGS_B_OFF:           rd_data_reg <= flags_b_reg;
          EVENT_FLAGS_C_OFF:           rd_data_reg <= flags_c_reg;
          EVENT_MASK_A_OFF:            rd_data_reg <= ctrl_reg.event_mask_a;
          EVENT_MASK_B_OFF:            rd_data_reg <= ctrl_reg.event_mask_b;
          EVENT_MASK_C_OFF:            rd_data_reg <= ctrl_reg.event_mask_c;
          BATTERY_THRESHOLD_CTRL_OFF:  rd_data_reg <= ctrl_reg.battery_threshold_ctrl;
          REGULATOR_OUTPUT_CTRL_OFF:   rd_data_reg <= ctrl_reg.regulator_output_ctrl;
          CHARGE_BEHAVIOUR_CTRL_OFF:   rd_data_reg <= ctrl_reg.charge_behaviour_ctrl;
          RESET_POWERPATH_CTRL_OFF:    rd_data_reg <= ctrl_reg.reset_powerpath_ctrl;
          FLOAT_VOLTAGE_SETTING_OFF:   rd_data_reg <= ctrl_reg.float_voltage_setting;
          CHARGE_CURRENT_SETTING_OFF:  rd_data_reg <= ctrl_reg.charge_current_setting;
          TERMINATION_PRECHARGE_OFF:   rd_data_reg <= ctrl_reg.termination_precharge_current;
          PRIMARY_INPUT_CURRENT_OFF:   rd_data_reg <= ctrl_reg.primary_input_current_limit;
          PRIMARY_INPUT_VOLTAGE_OFF:   rd_data_reg <= ctrl_reg.primary_input_voltage_limits;
          SECONDARY_INPUT_CURRENT_OFF: rd_data_reg <= ctrl_reg.secondary_input_current_limit;
          SECONDARY_INPUT_VOLTAGE_OFF: rd_data_reg <= ctrl_reg.secondary_input_voltage_limits;
          THERMISTOR_ZONE_CTRL_OFF:    rd_data_reg <= ctrl_reg.thermistor_zone_ctrl;
          CHARGE_TIMER_CTRL_OFF:       rd_data_reg <= ctrl_reg.charge_timer_ctrl;
          SAFETY_LIMIT_SETTING_OFF:    rd_data_reg <= ctrl_reg.safety_limit_setting;
          TOP_OFF_CTRL_OFF:            rd_data_reg <= ctrl_reg.top_off_ctrl;
          BOOST_CTRL_OFF:              rd_data_reg <= ctrl_reg.boost_ctrl;
          ADAPTER_DETECT_CTRL_OFF:     rd_data_reg <= ctrl_reg.adapter_detect_ctrl;
          COMPARATOR_MONITOR_A_OFF:    rd_data_reg <= monitor_a_reg;
          COMPARATOR_MONITOR_B_OFF:    rd_data_reg <= monitor_b_reg;
          DEVICE_IDENTITY_OFF:         rd_data_reg <= DEVICE_IDENTITY_VAL;
          FEATURE_OPTIONS_OFF:         rd_data_reg <= ctrl_reg.feature_options;
          default:                     rd_data_reg <= 8'h00;
        endcase
      end
    end
  end

  // Checks on the register bank behaviour
  sequence s_impedance_exit;
    impedance_prev_reg && !core_s.high_impedance_state;
  endsequence

  sequence s_enter_with_flag;
    impedance_enter && state_reg[STATE_BATT_LOW_BIT];
  endsequence

  property p_reset_defaults;
    @(posedge clk_sys) $past(sys_rst) |-> (ctrl_reg == CTRL_RST);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Settings not at default after reset");

  property p_reserved_one;
    @(posedge clk_sys) disable iff (sys_rst) state_reg[STATE_RESERVED_BIT];
  endproperty
  a_reserved_one: assert property (p_reserved_one)
    else $error("Reserved state bit read zero");

  property p_secondary_exclusive;
    @(posedge clk_sys) disable iff (sys_rst)
      state_reg[STATE_SECONDARY_BIT] |-> !state_reg[STATE_PRIMARY_BIT];
  endproperty
  a_secondary_exclusive: assert property (p_secondary_exclusive)
    else $error("Secondary valid with primary valid");

  property p_primary_valid;
    @(posedge clk_sys) disable iff (sys_rst)
      (core_s.primary_input_ok && !validation_busy_reg) |=> state_reg[STATE_PRIMARY_BIT];
  endproperty
  a_primary_valid: assert property (p_primary_valid)
    else $error("Primary valid flag missing");

  property p_weak_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      s_enter_with_flag |=> state_reg[STATE_BATT_LOW_BIT] [*2];
  endproperty
  a_weak_hold: assert property (p_weak_hold)
    else $error("Battery flag dropped in high impedance");

  property p_validate_on_exit;
    @(posedge clk_sys) disable iff (sys_rst)
      s_impedance_exit |=> validate_start_reg && validation_busy_reg;
  endproperty
  a_validate_on_exit: assert property (p_validate_on_exit)
    else $error("No validation after leaving high impedance");

  property p_charging_pin;
    @(posedge clk_sys) disable iff (sys_rst)
      core_s.top_off |=> !state_reg[STATE_CHARGING_BIT] && !charge_status_oe_reg;
  endproperty
  a_charging_pin: assert property (p_charging_pin)
    else $error("Charging bit set during top-off");

  property p_precharge;
    @(posedge clk_sys) disable iff (sys_rst)
      ##1 state_reg[STATE_PRECHARGE_BIT] == $past(core_s.precharge);
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("Pre-charge bit wrong");

  property p_sleep_absent;
    @(posedge clk_sys) disable iff (sys_rst)
      ##1 state_reg[1:0] == $past({core_s.sleep, core_s.battery_absent});
  endproperty
  a_sleep_absent: assert property (p_sleep_absent)
    else $error("Sleep or absent bit wrong");

  property p_ro_write_ignored;
    @(posedge clk_sys) disable iff (sys_rst)
      (req.wr && req.addr == DEVICE_IDENTITY_OFF) |=> $stable(ctrl_reg);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("Write to read-only offset changed settings");

endmodule // charger_register_bank

// ===== verif/host_model.sv
// Host side of the register port: one byte per request
module host_model
  import charger_regs_pkg::*;
(
  // Clock
  input  wire logic        clk_sys,
  // Register port
  output reg_req_type      req,
  input  wire logic  [7:0] rd_data_reg,
  input  wire logic        rd_valid_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Single byte write, strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req <= '0;
  endtask
  // Single byte read, answer taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(negedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    ok = (rd_valid_reg === 1'b1);
    d = rd_data_reg;
    req <= '0;
  endtask
endmodule // host_model

// ===== verif/charger_register_bank_tb.sv
module charger_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import charger_regs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  reg_req_type req;
  logic [7:0]  rd_data_reg;
  logic        rd_valid_reg;
  core_in_type core_in = CORE_IN_RST; // Battery only, no supply
  ctrl_type    ctrl_reg;
  logic        validate_start_reg;
  logic        charge_status_oe_reg;
  logic        charge_status_out_reg;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 32'h9ecf;
  logic [7:0]  d;
  logic [7:0]  v;
  bit          ok;
  always #50 clk_sys = ~clk_sys;
  charger_register_bank charger_register_bank_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req(req), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .core_in(core_in),
    .ctrl_reg(ctrl_reg), .validate_start_reg(validate_start_reg),
    .charge_status_out_reg(charge_status_out_reg), .charge_status_oe_reg(charge_status_oe_reg));
  host_model host_model_inst (.clk_sys(clk_sys), .req(req), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected state byte while no validation is pending
  function automatic logic [7:0] exp_state(core_in_type c);
    return {1'b1, c.secondary_rise_ok & ~c.primary_input_ok, c.primary_input_ok,
      c.battery_above_weak & c.charging, c.charging & ~c.top_off, c.precharge, c.sleep,
      c.battery_absent};
  endfunction
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask
  // Core levels need three edges to reach the state byte
  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    check({7'h00, ctrl_reg === CTRL_RST}, 8'h01);
    rd_chk(8'h00, 8'h82);
    rd_chk(8'h20, 8'h86);
    rd_chk(8'h21, 8'ha0);
    host_model_inst.wr(8'h00, 8'h00);
    rd_chk(8'h00, 8'h82);
    rd_chk(8'h03, 8'h00);
    // Write to the identity byte must change nothing
    host_model_inst.wr(8'h2d, 8'h00);
    rd_chk(8'h2d, DEVICE_IDENTITY_VAL);
    check({7'h00, ctrl_reg === CTRL_RST}, 8'h01);
    // Event edge sets a sticky flag; the read returns it and clears it
    core_in.events_a = 8'h3c;
    settle();
    rd_chk(8'h04, 8'h3c);
    rd_chk(8'h04, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      host_model_inst.wr(8'h12, v);
      rd_chk(8'h12, v);
    end
    // Random core flags, high impedance kept off
    for (int i = 0; i < 40; i++) begin
      core_in[65:58] = 8'($random(seed));
      settle();
      rd_chk(8'h00, exp_state(core_in));
      check({7'h00, charge_status_oe_reg}, {7'h00, core_in.charging & ~core_in.top_off});
      check({7'h00, charge_status_out_reg}, 8'h00);
    end
    core_in[65:58] = 8'h70;
    settle();
    core_in.high_impedance_state = 1'b1;
    settle();
    core_in.battery_above_weak = 1'b0;
    settle();
    rd_chk(8'h00, 8'hb8);
    core_in.high_impedance_state = 1'b0;
    for (int n = 0; n < 8 && validate_start_reg !== 1'b1; n++) @(negedge clk_sys);
    check({7'h00, validate_start_reg}, 8'h01);
    if (validate_start_reg !== 1'b1) finish_test();
    rd_chk(8'h00, 8'h98);
    core_in.validation_pass = 1'b1;
    settle();
    rd_chk(8'h00, 8'ha8);
    // Second reset in mid-run: defaults must come back
    sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    check({7'h00, ctrl_reg === CTRL_RST}, 8'h01);
    rd_chk(8'h00, 8'h82);
    rd_chk(8'h12, 8'h10);
    finish_test();
  end
endmodule // charger_register_bank_tb
